// ---- xie_cfg.svh ----
// constants for the exclusive-or instruction execute block
`ifndef XIE_CFG_SVH
`define XIE_CFG_SVH
`define XIE_OPC_TOP_POS      12
`define XIE_OPC_NIB_POS      8
`define XIE_DEST_POS         7
`define XIE_LIT_POS          0
`define XIE_FILE_POS         0
`define XIE_LIT_TOP          2'h3
`define XIE_LIT_NIB          4'ha
`define XIE_REG_TOP          2'h0
`define XIE_REG_NIB          4'h6
`define XIE_ACC_RESET        8'h00
`define XIE_ZERO_RESET       1'h0
`endif

// ---- xie_pkg.sv ----
// types for the exclusive-or instruction execute block
package xie_pkg;
    typedef enum logic [1:0] {
        XIE_PH_DECODE,
        XIE_PH_READ,
        XIE_PH_PROCESS,
        XIE_PH_WRITE
    } xie_phase_t;

    typedef enum logic [1:0] {
        XIE_OP_NONE,
        XIE_OP_XOR_LITERAL_INTO_ACCUMULATOR,
        XIE_OP_XOR_ACCUMULATOR_WITH_FILE
    } xie_op_t;

    typedef struct packed {
        logic       wrEn;
        logic [6:0] addr;
        logic [7:0] data;
    } xie_file_wr_t;
endpackage

// ---- xie_xor_execute.sv ----
// four-phase decode and execute of the two exclusive-or instructions
// ============================================================
// Functional notes
// - literal form xors accumulator with low instruction byte, result to accumulator, zero flag.
// - register form xors accumulator with addressed file register; result goes where destination selects, zero flag.
// - 11_1010 selects literal form; 00_0110 with destination and file field selects register.
// - destination 0 writes accumulator, destination 1 writes back the file register.
// - one word, one cycle of four phases: decode, read, process, write.
`include "xie_cfg.svh"

module xie_xor_execute #(
    parameter int DATA_W = 8,
    parameter int ADDR_W = 7
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire logic [13:0]          instrWord,
    output logic [ADDR_W-1:0]         fileRdAddr,
    input  wire logic [DATA_W-1:0]    fileRdData,
    output xie_pkg::xie_file_wr_t     fileWr,
    output xie_pkg::xie_phase_t       phase,
    output logic                      instrDone,
    output logic                      instrRecognized,
    output logic [DATA_W-1:0]         accumulator,
    output logic                      zeroFlag
);

    // ============================================================
    // decode
    function automatic xie_pkg::xie_op_t decodeOp(input logic [13:0] w);
        if (w[13:`XIE_OPC_TOP_POS] == `XIE_LIT_TOP &&
            w[11:`XIE_OPC_NIB_POS] == `XIE_LIT_NIB)
            return xie_pkg::XIE_OP_XOR_LITERAL_INTO_ACCUMULATOR;
        if (w[13:`XIE_OPC_TOP_POS] == `XIE_REG_TOP &&
            w[11:`XIE_OPC_NIB_POS] == `XIE_REG_NIB)
            return xie_pkg::XIE_OP_XOR_ACCUMULATOR_WITH_FILE;
        return xie_pkg::XIE_OP_NONE;
    endfunction

    // literal operand sits in the low byte of the word
    function automatic logic [DATA_W-1:0] litField(input logic [13:0] w);
        return w[`XIE_LIT_POS +: DATA_W];
    endfunction

    // file register address sits in the low bits of the word
    function automatic logic [ADDR_W-1:0] fileField(input logic [13:0] w);
        return w[`XIE_FILE_POS +: ADDR_W];
    endfunction

    // register form with destination bit set sends the result back to the file
    function automatic logic writesFile(input xie_pkg::xie_op_t op, input logic [13:0] w);
        return (op == xie_pkg::XIE_OP_XOR_ACCUMULATOR_WITH_FILE) && w[`XIE_DEST_POS];
    endfunction

    xie_pkg::xie_phase_t   phase_q,   phase_d;
    xie_pkg::xie_op_t      op_q,      op_d;
    logic [13:0]           instr_q,   instr_d;
    logic [DATA_W-1:0]     operand_q, operand_d;
    logic [DATA_W-1:0]     result_q,  result_d;
    logic [DATA_W-1:0]     acc_q,     acc_d;
    logic                  zero_q,    zero_d;
    xie_pkg::xie_file_wr_t wr_q,      wr_d;
    logic                  done_q,    done_d;
    logic                  recog_q,   recog_d;

    // ============================================================
    // phase strobes shared by the latch, operand, accumulator and write-back groups below
    logic inDecode;
    logic inRead;
    logic inProcess;
    logic inWrite;

    assign inDecode  = (phase_q == xie_pkg::XIE_PH_DECODE);
    assign inRead    = (phase_q == xie_pkg::XIE_PH_READ);
    assign inProcess = (phase_q == xie_pkg::XIE_PH_PROCESS);
    assign inWrite   = (phase_q == xie_pkg::XIE_PH_WRITE);

    // ============================================================
    // phase sequencer: one instruction every four clocks, no stalls
    // unrecognised words still take the full four phases
    always_comb begin
        phase_d = phase_q;
        unique case (phase_q)
            xie_pkg::XIE_PH_DECODE: begin
                phase_d = xie_pkg::XIE_PH_READ;
            end
            xie_pkg::XIE_PH_READ: begin
                phase_d = xie_pkg::XIE_PH_PROCESS;
            end
            xie_pkg::XIE_PH_PROCESS: begin
                phase_d = xie_pkg::XIE_PH_WRITE;
            end
            xie_pkg::XIE_PH_WRITE: begin
                phase_d = xie_pkg::XIE_PH_DECODE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            phase_q <= xie_pkg::XIE_PH_DECODE;
        end else begin
            phase_q <= phase_d;
        end
    end

    // ============================================================
    // instruction latch: the word is taken once, at the end of decode
    // the latched word keeps driving the file address until the next decode
    always_comb begin
        instr_d = instr_q;
        op_d    = op_q;
        recog_d = recog_q;
        if (inDecode) begin
            instr_d = instrWord;
            op_d    = decodeOp(instrWord);
            recog_d = (decodeOp(instrWord) != xie_pkg::XIE_OP_NONE);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            instr_q <= '0;
            op_q    <= xie_pkg::XIE_OP_NONE;
            recog_q <= 1'h0;
        end else begin
            instr_q <= instr_d;
            op_q    <= op_d;
            recog_q <= recog_d;
        end
    end

    // ============================================================
    // operand fetch and exclusive-or
    always_comb begin
        operand_d = operand_q;
        result_d  = result_q;
        if (inRead) begin
            // an unrecognised word reads the file too, but its result is dropped
            if (op_q == xie_pkg::XIE_OP_XOR_LITERAL_INTO_ACCUMULATOR) begin
                operand_d = litField(instr_q);
            end else begin
                operand_d = fileRdData;
            end
        end
        if (inProcess) begin
            result_d = acc_q ^ operand_q;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            operand_q <= '0;
            result_q  <= '0;
        end else begin
            operand_q <= operand_d;
            result_q  <= result_d;
        end
    end

    // ============================================================
    // accumulator and zero flag; carry flags live elsewhere and are never driven
    // an unrecognised word leaves both alone
    always_comb begin
        acc_d  = acc_q;
        zero_d = zero_q;
        if (inWrite && op_q != xie_pkg::XIE_OP_NONE) begin
            zero_d = (result_q == '0);
            if (!writesFile(op_q, instr_q)) begin
                acc_d = result_q;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            acc_q  <= `XIE_ACC_RESET;
            zero_q <= `XIE_ZERO_RESET;
        end else begin
            acc_q  <= acc_d;
            zero_q <= zero_d;
        end
    end

    // ============================================================
    // write-back and completion strobes
    // the file write is registered, so it lands one clock after the write phase,
    // still ahead of the next instruction's read phase
    always_comb begin
        wr_d   = '0;
        done_d = 1'h0;
        if (inWrite) begin
            done_d = 1'h1;
            if (writesFile(op_q, instr_q)) begin
                wr_d.wrEn = 1'h1;
                wr_d.addr = fileField(instr_q);
                wr_d.data = result_q;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wr_q   <= '0;
            done_q <= 1'h0;
        end else begin
            wr_q   <= wr_d;
            done_q <= done_d;
        end
    end

    // ============================================================
    // port drive: every output comes straight from a flip-flop

    assign fileRdAddr      = fileField(instr_q);
    assign fileWr          = wr_q;
    assign phase           = phase_q;
    assign instrDone       = done_q;
    assign instrRecognized = recog_q;
    assign accumulator     = acc_q;
    assign zeroFlag        = zero_q;

endmodule

// ---- xie_xor_execute_assertions.sv ----
// port assertions for the exclusive-or execute block
module xie_xor_execute_chk (
    input wire logic                  ref_clk,
    input wire logic                  rst,
    input wire logic [13:0]           instrWord,
    input wire logic [7:0]            fileRdData,
    input wire xie_pkg::xie_file_wr_t fileWr,
    input wire logic [1:0]            phase,
    input wire logic                  instrDone,
    input wire logic                  instrRecognized,
    input wire logic [7:0]            accumulator,
    input wire logic                  zeroFlag
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire dec = phase == 2'h0;
    wire [5:0] op = instrWord[13:8];
    sequence s_reg(d); dec && op == 6'h06 && instrWord[7] == d; endsequence
    sequence s_phase_walk; phase == 2'h1 ##1 phase == 2'h2 ##1 phase == 2'h3; endsequence
    a_phase_order: assert property (dec |=> s_phase_walk) else $error("phase order");
    a_lit_result: assert property (dec && op == 6'h3a |-> ##4
        accumulator == ($past(accumulator, 4) ^ $past(instrWord[7:0], 4))) else $error("lit");
    a_reg_to_acc: assert property (s_reg(1'b0) |-> ##4
        accumulator == ($past(accumulator, 4) ^ $past(fileRdData, 3))) else $error("reg");
    a_reg_writeback: assert property (s_reg(1'b1) |-> ##4 fileWr ==
        {1'b1, $past(instrWord[6:0], 4), $past(accumulator, 4) ^ $past(fileRdData, 3)})
        else $error("write back");
    a_zero_result: assert property (instrDone && instrRecognized |->
        zeroFlag == !(fileWr.wrEn ? fileWr.data : accumulator)) else $error("zero");
    a_other_word: assert property (dec && op != 6'h3a && op != 6'h06 |=>
        !instrRecognized) else $error("decode");
endmodule
bind xie_xor_execute xie_xor_execute_chk chk (.ref_clk(ref_clk), .rst(rst),
    .instrWord(instrWord), .fileRdData(fileRdData), .fileWr(fileWr), .phase(phase),
    .instrDone(instrDone), .instrRecognized(instrRecognized),
    .accumulator(accumulator), .zeroFlag(zeroFlag));

// ---- testbench.sv ----
// random bench for the exclusive-or execute block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
    $display("MISMATCH %0t %h %h", $time, a, e); end end
    logic ref_clk = 1'b0, rst = 1'b1, dn, rec, z, eZ = 1'b0, isL, isR;
    logic [13:0] w = 14'h0000;
    logic [7:0] mem [128], acc, rd, eAcc = 8'h00, r;
    logic [6:0] ra;
    xie_pkg::xie_file_wr_t fw;
    int n_fail = 0, n_checks = 0, cyc = 0;
    assign rd = mem[ra];
    xie_xor_execute uut (.ref_clk(ref_clk), .rst(rst), .instrWord(w), .fileRdAddr(ra),
        .fileRdData(rd), .fileWr(fw), .phase(), .instrDone(dn), .instrRecognized(rec),
        .accumulator(acc), .zeroFlag(z));
    task automatic close_out();
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic run(input logic [13:0] v);
        w = v;
        isL = v[13:8] == 6'h3a;
        isR = v[13:8] == 6'h06;
        @(posedge ref_clk);
        #1 r = eAcc ^ (isL ? v[7:0] : mem[v[6:0]]);
        repeat (3) @(posedge ref_clk);
        #1 `CHK(dn, 1'b1)
        `CHK(rec, isL | isR)
        `CHK(fw.wrEn, isR & v[7])
        if (isR & v[7]) `CHK({fw.addr, fw.data}, {v[6:0], r})
        if (isL | isR & !v[7]) eAcc = r;
        if (isL | isR) eZ = r == 8'h00;
        `CHK(acc, eAcc)
        `CHK(z, eZ)
    endtask
    initial forever #2.5 ref_clk = ~ref_clk;
    // far-side file register store and run limit
    always @(posedge ref_clk) begin
        if (fw.wrEn)
            mem[fw.addr] <= fw.data;
        cyc++;
        if (cyc > 2000) begin
            n_fail++;
            close_out();
        end
    end
    initial begin
        logic [13:0] v;
        void'($urandom(81448));
        for (int i = 0; i < 128; i++)
            mem[i] = 8'($urandom);
        repeat (6) @(posedge ref_clk);
        #1 rst = 1'b0;
        for (int i = 0; i < 400; i++) begin
            v = 14'($urandom);
            case (i % 4)
                0: v[13:8] = 6'h3a;
                1: v[13:8] = 6'h06;
                2: v = {6'h3a, eAcc};
                default: ;
            endcase
            run(v);
        end
        close_out();
    end
endmodule
